// [rtl/gpio_cfg_regs.vh]
`ifndef GPIO_CFG_REGS_VH
`define GPIO_CFG_REGS_VH

// serial frame
`define FRAME_BITS      5'h10
`define LAST_BIT        5'h0f
`define EXT_PREFIX      4'hf

// extended write map sub-addresses
`define SUB_CTL_A       4'h0
`define SUB_CTL_B       4'h1
`define SUB_DATA        4'h2

// normal write map: first control register and its read-address field
`define CTL1_WRITE_ADDR 4'h0
`define RADDR_MSB       6
`define RADDR_LSB       2

// 5-bit read addresses
`define RD_CTL_A        5'h1b
`define RD_CTL_B        5'h1c
`define RD_DATA         5'h1d

// reset values and implemented-bit masks
`define CTL_A_RESET     8'h00
`define CTL_B_RESET     8'h00
`define DATA_RESET      8'h00
`define RADDR_RESET     5'h00
`define CTL_A_MASK      8'hf0
`define CTL_B_MASK      8'hf7
`define DATA_MASK       8'hf0

// first pin control register fields
`define PIN1_ALERT_EN   4
`define PIN1_DIR        5
`define PIN1_POL        6
`define PIN1_SEL        7

// second pin control register fields
`define PIN4_ALERT_EN   0
`define PIN4_DIR        1
`define PIN4_POL        2
`define CTL_B_UNUSED    3
`define PIN3_ALERT_EN   4
`define PIN3_DIR        5
`define PIN3_POL        6
`define PIN3_SEL        7

// pin data register fields
`define PIN4_DAT        4
`define PIN3_DAT        5
`define PIN2_DAT        6
`define PIN1_DAT        7

`endif

// [rtl/sync_two_stage.v]
`timescale 1ns/1ps
module sync_two_stage #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             reset,
  // asynchronous inputs and their synchronised copies
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  // first stage is read by the second stage only
  reg [WIDTH-1:0] meta;

  always @(posedge clk_sys) begin
    if (reset) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// [rtl/gpio_config_and_data_regs.v]
`timescale 1ns/1ps
`include "gpio_cfg_regs.vh"
module gpio_config_and_data_regs (
  // clock and reset
  input  wire       clk_sys,
  input  wire       reset,
  // serial interface, mode 0, msb first
  input  wire       sclk,
  input  wire       cs_n,
  input  wire       din,
  output reg        dout,
  output reg        dout_oe,
  // general-purpose pin one
  input  wire       gp_pin_one_in,
  output reg        gp_pin_one_out,
  output reg        gp_pin_one_oe,
  // general-purpose pin two, data bit only
  output reg        gp_pin_two_data,
  // general-purpose pin three
  input  wire       gp_pin_three_in,
  output reg        gp_pin_three_out,
  output reg        gp_pin_three_oe,
  // general-purpose pin four
  input  wire       gp_pin_four_in,
  output reg        gp_pin_four_out,
  output reg        gp_pin_four_oe,
  // analog routing of the shared pins
  output reg        analog_input_one,
  output reg        analog_input_three,
  // per-pin alert requests: bit 0 pin one .. bit 3 pin four
  output reg  [3:0] pin_alert_request
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_HOLD  = 2'h2;

  // synchronised inputs
  wire [5:0] sync_out;
  wire       s_sclk;
  wire       s_cs_n;
  wire       s_din;
  wire       s_pin_one;
  wire       s_pin_three;
  wire       s_pin_four;

  // serial engine state
  reg  [1:0]  state;
  reg         sclk_d;
  reg         cs_n_d;
  reg  [15:0] shift_in;
  reg  [15:0] shift_out;
  reg  [4:0]  bit_count;
  wire        sclk_rise;
  wire        sclk_fall;
  wire        cs_fall;
  wire [15:0] next_word;
  wire [3:0]  word_prefix;
  wire [3:0]  word_sub;
  wire [7:0]  word_byte;
  wire        word_done;

  // registers
  reg  [7:0]  pin_control_a;
  reg  [7:0]  pin_control_b;
  reg  [7:0]  pin_data;
  reg  [4:0]  read_addr;

  // derived pin views
  reg  [7:0]  data_view;
  reg  [7:0]  read_byte;
  wire        pin1_active;
  wire        pin3_active;
  wire        pin4_active;
  wire        pin1_is_input;
  wire        pin3_is_input;
  wire        pin4_is_input;

  // next values of the registered pin-side outputs
  reg         next_gp_pin_one_out;
  reg         next_gp_pin_one_oe;
  reg         next_gp_pin_two_data;
  reg         next_gp_pin_three_out;
  reg         next_gp_pin_three_oe;
  reg         next_gp_pin_four_out;
  reg         next_gp_pin_four_oe;
  reg         next_analog_input_one;
  reg         next_analog_input_three;
  reg  [3:0]  next_pin_alert_request;

  // link and pin inputs pass two flops; the link clock is only sampled
  sync_two_stage #(
    .WIDTH (6)
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in ({sclk, cs_n, din, gp_pin_one_in, gp_pin_three_in, gp_pin_four_in}),
    .sync_out (sync_out)
  );

  assign s_sclk      = sync_out[5];
  assign s_cs_n      = sync_out[4];
  assign s_din       = sync_out[3];
  assign s_pin_one   = sync_out[2];
  assign s_pin_three = sync_out[1];
  assign s_pin_four  = sync_out[0];

  assign sclk_rise = s_sclk & ~sclk_d;
  assign sclk_fall = ~s_sclk & sclk_d;
  assign cs_fall   = ~s_cs_n & cs_n_d;
  assign next_word = {shift_in[14:0], s_din};

  // fields of the word as its last bit arrives
  assign word_prefix = next_word[15:12];
  assign word_sub    = next_word[11:8];
  assign word_byte   = next_word[7:0];
  assign word_done   = ~s_cs_n & (state == ST_SHIFT) & sclk_rise & (bit_count == `LAST_BIT);

  // a pin is an input only when routed to the pin function
  assign pin1_is_input = pin_control_a[`PIN1_SEL] & pin_control_a[`PIN1_DIR];
  assign pin3_is_input = pin_control_b[`PIN3_SEL] & pin_control_b[`PIN3_DIR];
  // pin four has no analog twin, so its direction alone decides
  assign pin4_is_input = pin_control_b[`PIN4_DIR];

  // active level: polarity 1 means high is asserted
  assign pin1_active = ~(s_pin_one ^ pin_control_a[`PIN1_POL]);
  assign pin3_active = ~(s_pin_three ^ pin_control_b[`PIN3_POL]);
  assign pin4_active = ~(s_pin_four ^ pin_control_b[`PIN4_POL]);

  // inputs read back their sampled asserted level, outputs their stored bit
  always @* begin
    data_view = pin_data & `DATA_MASK;
    if (pin1_is_input) begin
      data_view[`PIN1_DAT] = pin1_active;
    end
    if (pin3_is_input) begin
      data_view[`PIN3_DAT] = pin3_active;
    end
    if (pin4_is_input) begin
      data_view[`PIN4_DAT] = pin4_active;
    end
  end

  // read mux, addressed by the 5-bit read address
  always @* begin
    if (read_addr == `RD_CTL_A) begin
      read_byte = pin_control_a & `CTL_A_MASK;
    end else if (read_addr == `RD_CTL_B) begin
      read_byte = pin_control_b & `CTL_B_MASK;
    end else if (read_addr == `RD_DATA) begin
      read_byte = data_view;
    end else begin
      read_byte = 8'h00;
    end
  end

  // serial engine: framing, bit shifting and reply output
  always @(posedge clk_sys) begin
    if (reset) begin
      state         <= ST_IDLE;
      sclk_d        <= 1'b0;
      // matches the synchroniser's low reset, so no false select edge
      cs_n_d        <= 1'b0;
      shift_in      <= 16'h0000;
      shift_out     <= 16'h0000;
      bit_count     <= 5'h00;
      dout          <= 1'b0;
      dout_oe       <= 1'b0;
    end else begin
      sclk_d <= s_sclk;
      cs_n_d <= s_cs_n;
      if (s_cs_n) begin
        // deselect aborts any partial frame without writing
        state     <= ST_IDLE;
        dout_oe   <= 1'b0;
        dout      <= 1'b0;
        bit_count <= 5'h00;
      end else begin
        case (state)
          ST_IDLE: begin
            if (cs_fall) begin
              // reply word: address echo, zero pad, register byte
              shift_out <= {read_addr[3:0], 4'h0, read_byte};
              dout      <= read_addr[3];
              dout_oe   <= 1'b1;
              bit_count <= 5'h00;
              state     <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            if (sclk_rise) begin
              shift_in  <= next_word;
              bit_count <= bit_count + 5'h01;
              if (bit_count == `LAST_BIT) begin
                // the commit process writes the registers on this edge
                state <= ST_HOLD;
              end
            end else if (sclk_fall) begin
              shift_out <= {shift_out[14:0], 1'b0};
              dout      <= shift_out[14];
            end
          end
          ST_HOLD: begin
            // extra clocks after the sixteenth bit are ignored
            if (sclk_fall) begin
              dout <= 1'b0;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // register commit on the sixteenth rising edge of a live frame;
  // a frame cut short never gets here, so nothing half-written lands
  always @(posedge clk_sys) begin
    if (reset) begin
      pin_control_a <= `CTL_A_RESET;
      pin_control_b <= `CTL_B_RESET;
      pin_data      <= `DATA_RESET;
      read_addr     <= `RADDR_RESET;
    end else if (word_done) begin
      if (word_prefix == `EXT_PREFIX) begin
        // extended map: sub-address then eight data bits
        if (word_sub == `SUB_CTL_A) begin
          pin_control_a <= word_byte & `CTL_A_MASK;
        end else if (word_sub == `SUB_CTL_B) begin
          pin_control_b <= word_byte & `CTL_B_MASK;
        end else if (word_sub == `SUB_DATA) begin
          pin_data <= word_byte & `DATA_MASK;
        end
      end else if (word_prefix == `CTL1_WRITE_ADDR) begin
        // new read address only shows in the next frame's reply
        read_addr <= next_word[`RADDR_MSB:`RADDR_LSB];
      end
    end
  end

  // pin drivers, routing and alert requests
  always @* begin
    // routing: clear select keeps the analog input
    next_analog_input_one   = ~pin_control_a[`PIN1_SEL];
    next_analog_input_three = ~pin_control_b[`PIN3_SEL];
    // output when selected and direction is 0
    next_gp_pin_one_oe   = pin_control_a[`PIN1_SEL] & ~pin_control_a[`PIN1_DIR];
    next_gp_pin_three_oe = pin_control_b[`PIN3_SEL] & ~pin_control_b[`PIN3_DIR];
    // dedicated pin: driven whenever its direction says output
    next_gp_pin_four_oe  = ~pin_control_b[`PIN4_DIR];
    // data bit 1 drives the active level
    next_gp_pin_one_out   = ~(pin_data[`PIN1_DAT] ^ pin_control_a[`PIN1_POL]);
    next_gp_pin_three_out = ~(pin_data[`PIN3_DAT] ^ pin_control_b[`PIN3_POL]);
    next_gp_pin_four_out  = ~(pin_data[`PIN4_DAT] ^ pin_control_b[`PIN4_POL]);
    next_gp_pin_two_data  = pin_data[`PIN2_DAT];
    // requests: input, asserted and enabled; masked otherwise
    next_pin_alert_request[0] = pin1_is_input & pin1_active & pin_control_a[`PIN1_ALERT_EN];
    // pin two has no configuration here, so it never requests
    next_pin_alert_request[1] = 1'b0;
    next_pin_alert_request[2] = pin3_is_input & pin3_active & pin_control_b[`PIN3_ALERT_EN];
    next_pin_alert_request[3] = pin4_is_input & pin4_active & pin_control_b[`PIN4_ALERT_EN];
  end

  // every pin-side output comes straight from a flop
  always @(posedge clk_sys) begin
    if (reset) begin
      gp_pin_one_out     <= 1'b0;
      gp_pin_one_oe      <= 1'b0;
      gp_pin_two_data    <= 1'b0;
      gp_pin_three_out   <= 1'b0;
      gp_pin_three_oe    <= 1'b0;
      gp_pin_four_out    <= 1'b0;
      gp_pin_four_oe     <= 1'b0;
      analog_input_one   <= 1'b1;
      analog_input_three <= 1'b1;
      pin_alert_request  <= 4'h0;
    end else begin
      gp_pin_one_out     <= next_gp_pin_one_out;
      gp_pin_one_oe      <= next_gp_pin_one_oe;
      gp_pin_two_data    <= next_gp_pin_two_data;
      gp_pin_three_out   <= next_gp_pin_three_out;
      gp_pin_three_oe    <= next_gp_pin_three_oe;
      gp_pin_four_out    <= next_gp_pin_four_out;
      gp_pin_four_oe     <= next_gp_pin_four_oe;
      analog_input_one   <= next_analog_input_one;
      analog_input_three <= next_analog_input_three;
      pin_alert_request  <= next_pin_alert_request;
    end
  end

endmodule

// [verification/gpio_regs_asserts.sv]
`timescale 1ns/1ps
module gpio_regs_asserts (
  // clock and reset
  input logic       clk_sys,
  input logic       reset,
  // serial link
  input logic       cs_n,
  input logic       dout,
  input logic       dout_oe,
  // pin side
  input logic       gp_pin_one_out,
  input logic       gp_pin_one_oe,
  input logic       gp_pin_four_oe,
  input logic       analog_input_one,
  input logic       analog_input_three,
  input logic [3:0] pin_alert_request
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  reset_state_a: assert property (disable iff (1'b0) reset |=>
    !dout_oe && !pin_alert_request && analog_input_one && analog_input_three) else $error("reset state wrong");
  frame_open_a: assert property ($fell(cs_n) |-> ##[1:5] dout_oe) else $error("dout not enabled");
  frame_close_a: assert property (cs_n [*6] |-> !dout_oe) else $error("dout enabled while idle");
  idle_dout_a: assert property (!dout_oe |-> !dout) else $error("dout not low when off");
  sel_one_a: assert property (gp_pin_one_oe |-> !analog_input_one) else $error("pin one driven as analog");
  alert_one_a: assert property (pin_alert_request[0] |-> !gp_pin_one_oe && !analog_input_one)
    else $error("pin one alert wrong");
  alert_three_a: assert property (pin_alert_request[2] |-> !analog_input_three) else $error("pin three alert");
  alert_four_a: assert property (pin_alert_request[3] |-> !gp_pin_four_oe) else $error("pin four alert");
  // pin one drive and routing may only move as a result of a frame
  pins_hold_a: assert property (cs_n [*8] |-> $stable({gp_pin_one_out, gp_pin_one_oe, analog_input_one}))
    else $error("pin one moved while idle");
endmodule
bind gpio_config_and_data_regs gpio_regs_asserts chk (.clk_sys(clk_sys), .reset(reset), .cs_n(cs_n), .dout(dout),
  .dout_oe(dout_oe), .gp_pin_one_out(gp_pin_one_out), .gp_pin_one_oe(gp_pin_one_oe), .gp_pin_four_oe(gp_pin_four_oe),
  .analog_input_one(analog_input_one), .analog_input_three(analog_input_three), .pin_alert_request(pin_alert_request));

// [verification/serial_host.sv]
`timescale 1ns/1ps
module serial_host (
  // clock
  input  logic clk_sys,
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic din,
  input  logic dout
);
  int half = 8;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // one 16-bit word, msb first; reply sampled just before each rise
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    cs_n = 1'b0;
    gap(half);
    for (int i = 15; i >= 0; i--) begin
      din = w[i];
      gap(half);
      r[i] = dout;
      sclk = 1'b1;
      gap(half);
      sclk = 1'b0;
    end
    gap(half);
    cs_n = 1'b1;
    // released line must not keep the last bit
    din = ~din;
    gap(half);
  endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys, reset, sclk, cs_n, din, dout, dout_oe, i1, i3, i4;
  logic        o1, e1, d2, o3, e3, o4, e4, a1, a3;
  logic [3:0]  alert;
  logic [15:0] r;
  int          fail_count = 0;
  int          total_checks = 0;
  gpio_config_and_data_regs dut (.clk_sys(clk_sys), .reset(reset), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .dout_oe(dout_oe), .gp_pin_one_in(i1), .gp_pin_one_out(o1), .gp_pin_one_oe(e1),
    .gp_pin_two_data(d2), .gp_pin_three_in(i3), .gp_pin_three_out(o3), .gp_pin_three_oe(e3),
    .gp_pin_four_in(i4), .gp_pin_four_out(o4), .gp_pin_four_oe(e4), .analog_input_one(a1),
    .analog_input_three(a3), .pin_alert_request(alert));
  serial_host host (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] sub, input logic [7:0] v);
    host.xfer({4'hf, sub, v}, r);
  endtask
  // address goes in one frame, the reply comes in the next
  task rd(input logic [4:0] a, input logic [7:0] exp);
    host.xfer({9'h000, a, 2'b00}, r);
    host.xfer(16'h0000, r);
    chk(r, {a[3:0], 4'h0, exp});
  endtask
  task pins(input logic [8:0] e);
    chk({7'h00, a1, a3, e1, e3, e4, o1, d2, o3, o4}, {7'h00, e});
  endtask
  task conclude;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    conclude;
  end
  initial begin
    reset = 1'b1;
    {i1, i3, i4} = 3'b000;
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    pins(9'h19b);
    chk({12'h000, alert}, 16'h0000);
    rd(5'h1c, 8'h00);
    rd(5'h1d, 8'h00);
    wr(4'h1, 8'hff);
    rd(5'h1c, 8'hf7);
    wr(4'h0, 8'h80);
    wr(4'h1, 8'h80);
    wr(4'h2, 8'hff);
    pins(9'h074);
    rd(5'h1d, 8'hf0);
    wr(4'h0, 8'hc0);
    wr(4'h1, 8'hc4);
    pins(9'h07f);
    wr(4'h2, 8'h90);
    pins(9'h079);
    wr(4'h0, 8'hf0);
    wr(4'h1, 8'hf7);
    {i1, i3, i4} = 3'b111;
    repeat (8) @(negedge clk_sys);
    pins(9'h009);
    chk({12'h000, alert}, 16'h000d);
    rd(5'h1d, 8'hb0);
    wr(4'h1, 8'hf6);
    chk({12'h000, alert}, 16'h0005);
    wr(4'h1, 8'he7);
    chk({12'h000, alert}, 16'h0009);
    wr(4'h0, 8'hb0);
    chk({12'h000, alert}, 16'h0008);
    i1 = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk({12'h000, alert}, 16'h0009);
    conclude;
  end
endmodule
